// [shared/ddmc_pkg.sv]
// How it works
// R1 - Bypass bit at 1 routes the modulator path around its divide-by-2 stage.
// R2 - Each main datapath keeps its own bypass copy, chosen by the page select.
// R3 - Reset-hold bit resets to 1 and holds all digital logic in reset.
// R4 - Host clears reset-hold only after both clock loops report lock.
// R5 - Read-only bit 7 of link mode flags an unsupported mode and rate pairing.
// R6 - Host reprograms mode and rates whenever the invalid flag reads 1.
// R7 - In dual link, combine bit merges both sync requests into one.
// R8 - Six-bit link mode resets to 0x20; top bit picks dual link, low five the mode.
// R9 - Main interpolation code sits in bits 7:4, resets to 0x8.
// R10 - Channel interpolation code sits in bits 3:0, resets to 0x4.
// R11 - Reserved bits read zero; unlisted interpolation codes count as unsupported.
package ddmc_pkg;

    // ==========================================================
    // Bus geometry.
    localparam int ADDR_W = 12;
    localparam int IDX_W  = 10;

    // ==========================================================
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_MODSW = 10'h0ff;
    localparam logic [IDX_W-1:0] IDX_RESET = 10'h100;
    localparam logic [IDX_W-1:0] IDX_LINK  = 10'h110;
    localparam logic [IDX_W-1:0] IDX_INTRP = 10'h111;
    localparam logic [IDX_W-1:0] IDX_PAGE  = 10'h008;

    // ==========================================================
    // Field positions.
    localparam int BYPASS_BIT   = 1;
    localparam int HOLD_BIT     = 0;
    localparam int INVALID_BIT  = 7;
    localparam int COMBINE_BIT  = 6;
    localparam int DUAL_BIT     = 5;
    localparam int MAIN_LSB     = 4;
    localparam int CH_LSB       = 0;

    // ==========================================================
    // Reset values.
    localparam logic       HOLD_RST       = 1'b1;
    localparam logic       COMBINE_RST    = 1'b0;
    localparam logic       BYPASS_RST     = 1'b0;
    localparam logic [5:0] MODE_RST       = 6'h20;
    localparam logic [3:0] MAIN_CODE_RST  = 4'h8;
    localparam logic [3:0] CH_CODE_RST    = 4'h4;

    // ==========================================================
    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [src/ddmc_top.sv]
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module ddmc_top #(
    parameter int         NUM_DP     = 2,
    parameter logic [4:0] MODE_LIMIT = 5'h15
) (
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic [ddmc_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                     s_axi_awprot,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [ddmc_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                     s_axi_arprot,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire logic [1:0]                     link_sync_request_n_in,
    output logic [1:0]                          link_sync_request_outputs_n,
    output logic [NUM_DP-1:0]                   modpath_halving_bypass,
    output logic                                digital_reset_hold_bit,
    output logic                                dual_link,
    output logic [4:0]                          link_mode_field,
    output logic [3:0]                          main_path_interpolation_code,
    output logic [3:0]                          channel_interpolation_code,
    output logic                                mode_invalid
);

    // ==========================================================
    // Configuration state.
    logic [NUM_DP-1:0] bypass_ff;
    logic [NUM_DP-1:0] nxt_bypass;
    logic [NUM_DP-1:0] page_ff;
    logic [NUM_DP-1:0] nxt_page;
    logic              hold_ff;
    logic              nxt_hold;
    logic              combine_ff;
    logic              nxt_combine;
    logic [5:0]        mode_ff;
    logic [5:0]        nxt_mode;
    logic [3:0]        main_code_ff;
    logic [3:0]        nxt_main_code;
    logic [3:0]        ch_code_ff;
    logic [3:0]        nxt_ch_code;
    logic              invalid_ff;
    logic              nxt_invalid;
    logic [1:0]        sync_n_ff;
    logic [1:0]        nxt_sync_n;

    // ==========================================================
    // Write channel state.
    logic                          aw_have_ff;
    logic                          nxt_aw_have;
    logic [ddmc_pkg::IDX_W-1:0]    aw_idx_ff;
    logic [ddmc_pkg::IDX_W-1:0]    nxt_aw_idx;
    logic                          w_have_ff;
    logic                          nxt_w_have;
    logic [7:0]                    wbyte_ff;
    logic [7:0]                    nxt_wbyte;
    logic                          wlane_ff;
    logic                          nxt_wlane;
    logic                          bvalid_ff;
    logic                          nxt_bvalid;
    logic [1:0]                    bresp_ff;
    logic [1:0]                    nxt_bresp;

    // ==========================================================
    // Read channel state.
    logic                          rvalid_ff;
    logic                          nxt_rvalid;
    logic [31:0]                   rdata_ff;
    logic [31:0]                   nxt_rdata;
    logic [1:0]                    rresp_ff;
    logic [1:0]                    nxt_rresp;

    // ==========================================================
    // Decode helpers.
    logic                          commit;
    logic                          wr_hit;
    logic [ddmc_pkg::IDX_W-1:0]    ar_idx;
    logic                          rd_hit;
    logic [7:0]                    rd_byte;
    logic                          page_bypass;

    // Listed main datapath codes; anything else is unsupported.
    function automatic logic main_code_ok(input logic [3:0] c);
        case (c)
            4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc: main_code_ok = 1'b1; // R9 R11
            default:                             main_code_ok = 1'b0;
        endcase
    endfunction

    // Listed channel codes; anything else is unsupported.
    function automatic logic ch_code_ok(input logic [3:0] c);
        case (c)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8: ch_code_ok = 1'b1; // R10 R11
            default:                             ch_code_ok = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Write handshake: address and data are taken in either order and held
    // until both are present, then the write commits and the response rises.
    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready  = !w_have_ff && !bvalid_ff;
    assign commit        = aw_have_ff && w_have_ff;
    assign wr_hit        = (aw_idx_ff == ddmc_pkg::IDX_MODSW) || (aw_idx_ff == ddmc_pkg::IDX_RESET) ||
                           (aw_idx_ff == ddmc_pkg::IDX_LINK) || (aw_idx_ff == ddmc_pkg::IDX_INTRP) ||
                           (aw_idx_ff == ddmc_pkg::IDX_PAGE);

    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_aw_idx  = aw_idx_ff;
        nxt_w_have  = w_have_ff;
        nxt_wbyte   = wbyte_ff;
        nxt_wlane   = wlane_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_have = 1'b1;
            nxt_aw_idx  = s_axi_awaddr[ddmc_pkg::ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_have = 1'b1;
            nxt_wbyte  = s_axi_wdata[7:0];
            nxt_wlane  = s_axi_wstrb[0];
        end
        if (commit) begin
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = wr_hit ? ddmc_pkg::RESP_OKAY : ddmc_pkg::RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Write channel registers; reset leaves both ready lines high.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            aw_idx_ff  <= '0;
            w_have_ff  <= 1'b0;
            wbyte_ff   <= 8'h00;
            wlane_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= ddmc_pkg::RESP_OKAY;
        end else begin
            aw_have_ff <= nxt_aw_have;
            aw_idx_ff  <= nxt_aw_idx;
            w_have_ff  <= nxt_w_have;
            wbyte_ff   <= nxt_wbyte;
            wlane_ff   <= nxt_wlane;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
        end
    end

    // Response straight from flops, so it cannot glitch while bready is low.
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ==========================================================
    // Paged bypass copies: a write lands in every datapath whose page bit is
    // set, so software may program both copies in one access.
    generate
        for (genvar i = 0; i < NUM_DP; i++) begin : g_dp
            always_comb begin
                nxt_bypass[i] = bypass_ff[i];
                if (commit && wlane_ff && aw_idx_ff == ddmc_pkg::IDX_MODSW && page_ff[i]) begin
                    nxt_bypass[i] = wbyte_ff[ddmc_pkg::BYPASS_BIT]; // R2
                end
            end
        end
    endgenerate

    // Read side of the paged register shows the lowest selected copy.
    always_comb begin
        page_bypass = 1'b0;
        for (int i = NUM_DP - 1; i >= 0; i--) begin
            if (page_ff[i]) begin
                page_bypass = bypass_ff[i]; // R2
            end
        end
    end

    // ==========================================================
    // Plain fields. Only byte lane 0 carries register data; reserved bits
    // are simply not stored, so writes to them vanish.
    always_comb begin
        nxt_page      = page_ff;
        nxt_hold      = hold_ff;
        nxt_combine   = combine_ff;
        nxt_mode      = mode_ff;
        nxt_main_code = main_code_ff;
        nxt_ch_code   = ch_code_ff;
        if (commit && wlane_ff) begin
            case (aw_idx_ff)
                ddmc_pkg::IDX_PAGE: begin
                    nxt_page = wbyte_ff[NUM_DP-1:0];
                end
                ddmc_pkg::IDX_RESET: begin
                    nxt_hold = wbyte_ff[ddmc_pkg::HOLD_BIT]; // R3
                end
                ddmc_pkg::IDX_LINK: begin
                    nxt_combine = wbyte_ff[ddmc_pkg::COMBINE_BIT]; // R7
                    nxt_mode    = wbyte_ff[5:0]; // R8
                end
                ddmc_pkg::IDX_INTRP: begin
                    nxt_main_code = wbyte_ff[ddmc_pkg::MAIN_LSB +: 4]; // R9
                    nxt_ch_code   = wbyte_ff[ddmc_pkg::CH_LSB +: 4]; // R10
                end
                default: begin
                    nxt_page = page_ff;
                end
            endcase
        end
    end

    // ==========================================================
    // Invalid pairing check: both codes must be listed and the mode number
    // must lie within the supported range. Registered so the flag is stable.
    // Limitation: only the code lists and a mode ceiling are checked; the
    // full table of legal mode and rate pairings is not modelled.
    always_comb begin
        nxt_invalid = !main_code_ok(main_code_ff) || !ch_code_ok(ch_code_ff) ||
                      (mode_ff[4:0] > MODE_LIMIT); // R5 R11
    end

    // ==========================================================
    // Sync request routing; requests are active low. While the digital
    // logic is held in reset both outputs request, so the links resync on
    // release instead of trusting stale alignment.
    always_comb begin
        if (hold_ff) begin
            nxt_sync_n = 2'b00; // R3
        end else if (!mode_ff[ddmc_pkg::DUAL_BIT]) begin
            nxt_sync_n = {1'b1, link_sync_request_n_in[0]};
        end else if (combine_ff) begin
            nxt_sync_n = {2{&link_sync_request_n_in}}; // R7
        end else begin
            nxt_sync_n = link_sync_request_n_in;
        end
    end

    // Configuration registers. The page select resets to all ones so that a
    // first write after reset reaches every datapath copy.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bypass_ff    <= {NUM_DP{ddmc_pkg::BYPASS_RST}};
            page_ff      <= {NUM_DP{1'b1}};
            hold_ff      <= ddmc_pkg::HOLD_RST; // R3
            combine_ff   <= ddmc_pkg::COMBINE_RST;
            mode_ff      <= ddmc_pkg::MODE_RST; // R8
            main_code_ff <= ddmc_pkg::MAIN_CODE_RST;
            ch_code_ff   <= ddmc_pkg::CH_CODE_RST;
            invalid_ff   <= 1'b0;
            sync_n_ff    <= 2'b00;
        end else begin
            bypass_ff    <= nxt_bypass;
            page_ff      <= nxt_page;
            hold_ff      <= nxt_hold;
            combine_ff   <= nxt_combine;
            mode_ff      <= nxt_mode;
            main_code_ff <= nxt_main_code;
            ch_code_ff   <= nxt_ch_code;
            invalid_ff   <= nxt_invalid;
            sync_n_ff    <= nxt_sync_n;
        end
    end

    // ==========================================================
    // Read path: one read at a time, answered the cycle after it is taken.
    assign s_axi_arready = !rvalid_ff;
    assign ar_idx        = s_axi_araddr[ddmc_pkg::ADDR_W-1:2];

    // Read decode on the live address; a write committing on the same edge shows up one read later.
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (ar_idx)
            ddmc_pkg::IDX_MODSW: rd_byte[ddmc_pkg::BYPASS_BIT] = page_bypass; // R1 R11
            ddmc_pkg::IDX_RESET: rd_byte[ddmc_pkg::HOLD_BIT]   = hold_ff;
            ddmc_pkg::IDX_LINK:  rd_byte = {invalid_ff, combine_ff, mode_ff}; // R5
            ddmc_pkg::IDX_INTRP: rd_byte = {main_code_ff, ch_code_ff};
            ddmc_pkg::IDX_PAGE:  rd_byte[NUM_DP-1:0] = page_ff;
            default:             rd_hit = 1'b0;
        endcase
    end

    // Read capture; arready drops while an answer waits, so no read overwrites it.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = {24'h000000, rd_byte};
            nxt_rresp  = rd_hit ? ddmc_pkg::RESP_OKAY : ddmc_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Read channel registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= ddmc_pkg::RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // Read answer straight from flops.
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // ==========================================================
    // Outputs to the datapath, all straight from flops.
    assign modpath_halving_bypass       = bypass_ff; // R1
    assign digital_reset_hold_bit       = hold_ff; // R3
    assign dual_link                    = mode_ff[ddmc_pkg::DUAL_BIT]; // R8
    assign link_mode_field              = mode_ff[4:0];
    assign main_path_interpolation_code = main_code_ff;
    assign channel_interpolation_code   = ch_code_ff;
    assign mode_invalid                 = invalid_ff;
    assign link_sync_request_outputs_n  = sync_n_ff;

endmodule

// [testbench/ddmc_sva.sv]
`timescale 1ns/1ns
module ddmc_sva #(
    parameter logic [4:0] MODE_LIMIT = 5'h15
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [1:0] link_sync_request_n_in,
    input wire logic [1:0] link_sync_request_outputs_n,
    input wire logic       digital_reset_hold_bit,
    input wire logic       dual_link,
    input wire logic [4:0] link_mode_field,
    input wire logic [3:0] main_path_interpolation_code,
    input wire logic [3:0] channel_interpolation_code,
    input wire logic       mode_invalid
);
    // ==========================================================
    // Code legality, kept apart so each check names one cause.
    logic main_ok;
    logic ch_ok;
    assign main_ok = main_path_interpolation_code inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc};
    assign ch_ok   = channel_interpolation_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};

    // ==========================================================
    // Checks; all sit in the one clock domain.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_reset_values: assert property ($rose(aresetn) |-> digital_reset_hold_bit && dual_link &&
        link_mode_field == 5'h00 && main_path_interpolation_code == 4'h8 && channel_interpolation_code == 4'h4)
        else $error("register reset values wrong");
    chk_sync_held: assert property ($past(digital_reset_hold_bit) |-> link_sync_request_outputs_n == 2'b00)
        else $error("sync output not requesting while held");
    chk_sync_single: assert property (!$past(digital_reset_hold_bit) && !$past(dual_link) |->
        link_sync_request_outputs_n == {1'b1, $past(link_sync_request_n_in[0])})
        else $error("single link sync output wrong");
    chk_sync_dual: assert property (!$past(digital_reset_hold_bit) && $past(dual_link) |->
        link_sync_request_outputs_n == $past(link_sync_request_n_in) ||
        link_sync_request_outputs_n == {2{&$past(link_sync_request_n_in)}})
        else $error("dual link sync output wrong");
    chk_main_bad: assert property (!main_ok |=> mode_invalid)
        else $error("bad main code not flagged");
    chk_ch_bad: assert property (!ch_ok |=> mode_invalid)
        else $error("bad channel code not flagged");
    chk_combo_good: assert property (main_ok && ch_ok && link_mode_field <= MODE_LIMIT |=> !mode_invalid)
        else $error("good setting flagged");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    cover property (dual_link && link_sync_request_outputs_n == 2'b00 && link_sync_request_n_in != 2'b00);
    cover property ($rose(mode_invalid));
    cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind ddmc_top ddmc_sva #(.MODE_LIMIT(MODE_LIMIT)) i_ddmc_sva (.*);

// [testbench/testbench.sv]
`timescale 1ns/1ns
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("unexpected %0t: %s", $time, m); end end
module testbench;
    // ==========================================================
    // Signals carry the port names so the instance connects by name.
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        digital_reset_hold_bit, dual_link, mode_invalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, link_sync_request_n_in, link_sync_request_outputs_n;
    logic [1:0]  modpath_halving_bypass, rsp;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb, main_path_interpolation_code, channel_interpolation_code;
    logic [4:0]  link_mode_field;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    int          n_fail, checks_done;
    localparam logic [4:0] LIM = 5'h15;

    ddmc_top #(.NUM_DP(2), .MODE_LIMIT(LIM)) i_ddmc_top (.*);

    // Free-running 100 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ==========================================================
    // Closing and bus tasks.
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Handshakes are judged at the falling edge, so the rising edge that takes them is never raced.
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] st, output logic [1:0] r);
        logic ha, hw, ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            ta = ta || ha;
            tw = tw || hw;
        end
        do begin
            @(negedge aclk);
            ha = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!ha);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic h;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            h = s_axi_arvalid && s_axi_arready;
            @(posedge aclk);
        end while (!h);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!h);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wc(input logic [9:0] idx, input logic [7:0] d);
        wr(idx, d, 4'hf, rsp);
        `CHK(rsp, ddmc_pkg::RESP_OKAY, "write response")
    endtask

    task automatic rc(input logic [9:0] idx, input logic [7:0] e);
        rd(idx, rdat, rsp);
        `CHK({rsp, rdat}, {ddmc_pkg::RESP_OKAY, 24'h0, e}, "read data")
    endtask

    // The output flop lags the input by one edge; two edges leave margin.
    task automatic sy(input logic [1:0] i, input logic [1:0] e);
        @(posedge aclk);
        link_sync_request_n_in <= i;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        `CHK(link_sync_request_outputs_n, e, "sync request output")
    endtask

    function automatic logic ok(input logic [3:0] m, input logic [3:0] c, input logic [4:0] md);
        return (m inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc}) && (c inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8}) &&
            (md <= LIM);
    endfunction

    // ==========================================================
    // Main sequence.
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
        link_sync_request_n_in = 2'b11;
        n_fail = 0;
        checks_done = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rc(ddmc_pkg::IDX_MODSW, 8'h00);
        rc(ddmc_pkg::IDX_RESET, 8'h01);
        rc(ddmc_pkg::IDX_LINK, 8'h20);
        rc(ddmc_pkg::IDX_INTRP, 8'h84);
        rc(ddmc_pkg::IDX_PAGE, 8'h03);
        sy(2'b11, 2'b00);
        rd(10'h3ff, rdat, rsp);
        `CHK({rsp, rdat}, {ddmc_pkg::RESP_SLVERR, 32'h0}, "unmapped read")
        wr(10'h3ff, 8'hff, 4'hf, rsp);
        `CHK(rsp, ddmc_pkg::RESP_SLVERR, "unmapped write")
        $display("test reset and decode done");
        // The bench clock is stable from the start, so the hold may be cleared now.
        wc(ddmc_pkg::IDX_RESET, 8'hfe);
        rc(ddmc_pkg::IDX_RESET, 8'h00);
        `CHK(digital_reset_hold_bit, 1'b0, "hold not released")
        sy(2'b10, 2'b10);
        wc(ddmc_pkg::IDX_LINK, 8'hff);
        rc(ddmc_pkg::IDX_LINK, 8'hff);
        `CHK(mode_invalid, 1'b1, "invalid flag low")
        wc(ddmc_pkg::IDX_LINK, 8'h36);
        rc(ddmc_pkg::IDX_LINK, 8'hb6);
        wc(ddmc_pkg::IDX_LINK, 8'h35);
        rc(ddmc_pkg::IDX_LINK, 8'h35);
        wc(ddmc_pkg::IDX_LINK, 8'h65);
        `CHK({dual_link, link_mode_field}, 6'h25, "link mode outputs")
        sy(2'b01, 2'b00);
        sy(2'b11, 2'b11);
        wc(ddmc_pkg::IDX_LINK, 8'h45);
        sy(2'b01, 2'b11);
        wc(ddmc_pkg::IDX_LINK, 8'h25);
        sy(2'b01, 2'b01);
        $display("test link mode done");
        for (int k = 0; k < 16; k++) begin
            wc(ddmc_pkg::IDX_INTRP, {k[3:0], 4'h4});
            rc(ddmc_pkg::IDX_LINK, {~ok(k[3:0], 4'h4, 5'h05), 7'h25});
            `CHK(main_path_interpolation_code, k[3:0], "main code output")
        end
        for (int k = 0; k < 16; k++) begin
            wc(ddmc_pkg::IDX_INTRP, {4'h8, k[3:0]});
            rc(ddmc_pkg::IDX_LINK, {~ok(4'h8, k[3:0], 5'h05), 7'h25});
            `CHK(channel_interpolation_code, k[3:0], "channel code output")
        end
        wr(ddmc_pkg::IDX_INTRP, 8'h11, 4'h0, rsp);
        `CHK(rsp, ddmc_pkg::RESP_OKAY, "strobeless write response")
        rc(ddmc_pkg::IDX_INTRP, 8'h8f);
        $display("test interpolation done");
        wc(ddmc_pkg::IDX_PAGE, 8'h01);
        wc(ddmc_pkg::IDX_MODSW, 8'hff);
        rc(ddmc_pkg::IDX_MODSW, 8'h02);
        `CHK(modpath_halving_bypass, 2'b01, "bypass copy 0")
        wc(ddmc_pkg::IDX_PAGE, 8'h02);
        rc(ddmc_pkg::IDX_MODSW, 8'h00);
        wc(ddmc_pkg::IDX_MODSW, 8'h02);
        `CHK(modpath_halving_bypass, 2'b11, "bypass copy 1")
        wc(ddmc_pkg::IDX_PAGE, 8'h03);
        wc(ddmc_pkg::IDX_MODSW, 8'h00);
        `CHK(modpath_halving_bypass, 2'b00, "bypass cleared")
        $display("test bypass paging done");
        wc(ddmc_pkg::IDX_RESET, 8'h01);
        sy(2'b11, 2'b00);
        $display("test hold again done");
        wrap_up();
    end

    // Whole run needs a few hundred cycles; this cuts a hung handshake short.
    initial begin
        #100000;
        n_fail++;
        $display("unexpected %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
